// ### hdl/sensor_ctl_cfg.svh
// Constants for the sensor mode and timing control block
`ifndef SENSOR_CTL_CFG_SVH
`define SENSOR_CTL_CFG_SVH
`define INIT_MIN_CYCLES    8
`define STARTUP_CYCLES     4
`define BIT_STANDBY        0
`define BIT_EXT_BIAS       1
`define BIT_STATE_RESET    1
`define BIT_TRI_ALL        0
`define BIT_SYNC_EXTERNAL  0
`define BIT_SYNC_SINGLE_FRAME_ROLLING_SHUTTER 1
`define ROW_PIXELS         16'h0010
`define FRAME_ROWS         16'h0008
`define DEF_SOF_DELAY      8'h02
`define DEF_ROW_DELAY      8'h02
`define DEF_SOF_LEN        4'h1
`define DEF_ROW_LEN        4'h1
`define DEF_PIX_DELAY      8'h01
`endif

// ### hdl/sensor_ctl_device.sv
// Sensor end: mode control and frame/row/pixel timing generation
//
// Functional notes
// - Init high resets registers; low resumes
// - Controller holds init at least 8 clocks
// - Startup clears counters, loads defaults first
// - Init held high keeps low power
// - Init stops timing, tristates, refuses writes
// - After init, resume at first frame
// - Power bit 0 enters and leaves standby
// - Standby freezes timing, keeps registers, writable
// - Reset bit 1 enters and leaves state reset
// - State reset restarts sequencing, analog stays on
// - Clearing state reset starts new frame
// - Tristate register floats timing and pixel outputs
// - Power bias bit selects external resistor
// - Capture start marks integration in rolling mode
// - Capture start internal or external by setting
// - Row start delay and length programmable
// - Row advance delay and length programmable
// - Pixel valid per pixel, delay programmable
`timescale 1ns/1ps
`include "sensor_ctl_cfg.svh"
module sensor_ctl_device (
  input  wire logic core_clk,
  input  wire logic srst,
  sensor_ctl_if.device lnk
);
  //////////////////////////////////////////////////////////////////////////////
  // Programmable registers
  logic [7:0] power_q, power_d, rstc_q, rstc_d, tri_q, tri_d, sync_q, sync_d;
  logic [7:0] sofd_q, sofd_d, rowd_q, rowd_d, len_q, len_d, pixd_q, pixd_d;
  logic       in_init;
  logic       standby;
  logic       st_reset;
  logic       seq_ready;
  sensor_ctl_pkg::seq_state_t state_q, state_d;

  assign in_init  = srst | lnk.init;
  assign standby  = power_q[`BIT_STANDBY];
  assign st_reset = rstc_q[`BIT_STATE_RESET];
  // The idle cycle between init release and startup is refused as well,
  // otherwise a write could land there and be wiped by the default reload
  assign seq_ready = !in_init && (state_q != sensor_ctl_pkg::ST_INIT) &&
                     (state_q != sensor_ctl_pkg::ST_STARTUP);
  // Writes accepted only after startup, also in standby and state reset
  assign lnk.cfg_accept = seq_ready;

  // Register next values; init reloads defaults
  always_comb begin
    power_d = power_q;
    rstc_d  = rstc_q;
    tri_d   = tri_q;
    sync_d  = sync_q;
    sofd_d  = sofd_q;
    rowd_d  = rowd_q;
    len_d   = len_q;
    pixd_d  = pixd_q;
    if (in_init || state_q == sensor_ctl_pkg::ST_STARTUP) begin
      power_d = 8'h00;
      rstc_d  = 8'h00;
      tri_d   = 8'h00;
      sync_d  = 8'h00;
      sofd_d  = `DEF_SOF_DELAY;
      rowd_d  = `DEF_ROW_DELAY;
      len_d   = {`DEF_ROW_LEN, `DEF_SOF_LEN};
      pixd_d  = `DEF_PIX_DELAY;
    end else if (lnk.cfg_we && lnk.cfg_accept) begin
      power_d = lnk.cfg_power;
      rstc_d  = lnk.cfg_reset;
      tri_d   = lnk.cfg_tristate;
      sync_d  = lnk.cfg_sync;
      sofd_d  = lnk.cfg_sof_delay;
      rowd_d  = lnk.cfg_row_delay;
      len_d   = lnk.cfg_lengths;
      pixd_d  = lnk.cfg_pix_delay;
    end
  end

  always_ff @(posedge core_clk) begin
    power_q <= power_d;
    rstc_q  <= rstc_d;
    tri_q   <= tri_d;
    sync_q  <= sync_d;
    sofd_q  <= sofd_d;
    rowd_q  <= rowd_d;
    len_q   <= len_d;
    pixd_q  <= pixd_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: startup, frame start delay, row delay, pixel run
  logic [15:0] cnt_q, cnt_d, row_q, row_d;
  logic [7:0]  pdly_q, pdly_d;
  logic [3:0]  sofl_q, sofl_d, rowl_q, rowl_d;
  logic        pv_q, pv_d, cap_q, cap_d;
  sensor_ctl_pkg::pixel_t pix_q, pix_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    row_d   = row_q;
    pdly_d  = pdly_q;
    sofl_d  = (sofl_q != 4'h0) ? sofl_q - 4'h1 : 4'h0;
    rowl_d  = (rowl_q != 4'h0) ? rowl_q - 4'h1 : 4'h0;
    pv_d    = 1'b0;
    cap_d   = 1'b0;
    pix_d   = pix_q;
    if (in_init) begin
      state_d = sensor_ctl_pkg::ST_INIT;
      cnt_d   = 16'h0000;
      row_d   = 16'h0000;
      pdly_d  = 8'h00;
      sofl_d  = 4'h0;
      rowl_d  = 4'h0;
      pix_d   = 10'h000;
    end else if (st_reset && state_q != sensor_ctl_pkg::ST_STARTUP) begin
      state_d = sensor_ctl_pkg::ST_FRAME;
      cnt_d   = 16'h0000;
      row_d   = 16'h0000;
      pdly_d  = 8'h00;
      sofl_d  = 4'h0;
      rowl_d  = 4'h0;
    end else if (standby) begin
      // Timing frozen; sequencing resumes where it stopped
      sofl_d = sofl_q;
      rowl_d = rowl_q;
    end else begin
      case (state_q)
        sensor_ctl_pkg::ST_INIT: begin
          state_d = sensor_ctl_pkg::ST_STARTUP;
          cnt_d   = 16'h0000;
        end
        sensor_ctl_pkg::ST_STARTUP: begin
          cnt_d = cnt_q + 16'h0001;
          if (cnt_q == 16'(`STARTUP_CYCLES - 1)) begin
            state_d = sensor_ctl_pkg::ST_FRAME;
            cnt_d   = 16'h0000;
          end
        end
        sensor_ctl_pkg::ST_FRAME: begin
          // Internal capture start marks integration at frame begin
          if (cnt_q == 16'h0000) cap_d = sync_q[`BIT_SYNC_SINGLE_FRAME_ROLLING_SHUTTER];
          cnt_d = cnt_q + 16'h0001;
          if (cnt_q == {8'h00, sofd_q}) begin
            sofl_d  = len_q[3:0];
            state_d = sensor_ctl_pkg::ST_ROW;
            cnt_d   = 16'h0000;
            row_d   = 16'h0000;
          end
        end
        sensor_ctl_pkg::ST_ROW: begin
          cnt_d = cnt_q + 16'h0001;
          if (cnt_q == {8'h00, rowd_q}) begin
            rowl_d  = len_q[7:4];
            state_d = sensor_ctl_pkg::ST_PIXELS;
            cnt_d   = 16'h0000;
            pdly_d  = pixd_q;
          end
        end
        sensor_ctl_pkg::ST_PIXELS: begin
          if (pdly_q != 8'h00) begin
            pdly_d = pdly_q - 8'h01;
          end else begin
            pv_d  = 1'b1;
            pix_d = pix_q + 10'h001;
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q == `ROW_PIXELS - 16'h0001) begin
              cnt_d   = 16'h0000;
              row_d   = row_q + 16'h0001;
              state_d = (row_q == `FRAME_ROWS - 16'h0001) ?
                        sensor_ctl_pkg::ST_FRAME : sensor_ctl_pkg::ST_ROW;
            end
          end
        end
        default: state_d = sensor_ctl_pkg::ST_INIT;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    state_q <= state_d;
    cnt_q   <= cnt_d;
    row_q   <= row_d;
    pdly_q  <= pdly_d;
    sofl_q  <= sofl_d;
    rowl_q  <= rowl_d;
    pv_q    <= pv_d;
    cap_q   <= cap_d;
    pix_q   <= pix_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs and enables
  logic ext_sync;
  assign ext_sync                 = sync_q[`BIT_SYNC_EXTERNAL];
  assign lnk.row_start_o          = (sofl_q != 4'h0);
  assign lnk.row_advance_signal_o = (rowl_q != 4'h0);
  assign lnk.pixel_valid_o        = pv_q;
  assign lnk.pixel_data           = pix_q;
  assign lnk.flash_trigger_o      = 1'b0;   // Flash timing lives elsewhere
  // External mode samples the pin instead of driving it
  assign lnk.capture_start_o      = ext_sync ? lnk.sync_in : cap_q;
  assign lnk.capture_start_oe     = !in_init && !ext_sync && !tri_q[`BIT_TRI_ALL];
  assign lnk.timing_oe            = !in_init && !tri_q[`BIT_TRI_ALL];
  assign lnk.pixel_oe             = !in_init && !tri_q[`BIT_TRI_ALL];
  // Standby powers analog down; state reset does not
  assign lnk.analog_power_down    = in_init || standby;
  assign lnk.ext_bias_sel         = power_q[`BIT_EXT_BIAS];
  assign lnk.ready                = seq_ready;
endmodule : sensor_ctl_device

// ### hdl/sensor_ctl_host.sv
// Controller end: init pulse, configuration writes, timing capture
`timescale 1ns/1ps
`include "sensor_ctl_cfg.svh"
module sensor_ctl_host (
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  input  wire logic                   init_req,
  input  wire logic                   hold_low_power,
  input  wire logic                   wr_req,
  input  wire logic [63:0]            wr_cfg,
  input  wire logic                   ext_sync_level,
  output logic                        init_busy,
  output logic                        wr_done,
  output logic                        pixel_strobe,
  output sensor_ctl_pkg::pixel_t      pixel_value,
  output logic                        row_begin,
  output logic                        frame_begin,
  sensor_ctl_if.host                  lnk
);
  //////////////////////////////////////////////////////////////////////////////
  // Init pulse of at least the minimum width, or held for low power
  logic [3:0] icnt_q, icnt_d;
  always_comb begin
    icnt_d = icnt_q;
    if (srst || init_req) icnt_d = 4'(`INIT_MIN_CYCLES);
    else if (icnt_q != 4'h0) icnt_d = icnt_q - 4'h1;
  end
  always_ff @(posedge core_clk) begin
    icnt_q <= icnt_d;
  end
  assign lnk.init   = (icnt_q != 4'h0) || hold_low_power;
  assign init_busy  = lnk.init;
  assign lnk.sync_in = ext_sync_level;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration write: held until the device accepts
  logic [63:0] cfg_q, cfg_d;
  logic        pend_q, pend_d, done_q, done_d;
  always_comb begin
    cfg_d  = cfg_q;
    pend_d = pend_q;
    done_d = 1'b0;
    if (srst) begin
      pend_d = 1'b0;
    end else if (wr_req && !pend_q) begin
      cfg_d  = wr_cfg;
      pend_d = 1'b1;
    end else if (pend_q && lnk.cfg_accept && !lnk.init) begin
      pend_d = 1'b0;
      done_d = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    cfg_q  <= cfg_d;
    pend_q <= pend_d;
    done_q <= done_d;
  end
  assign lnk.cfg_we        = pend_q && !lnk.init;
  assign lnk.cfg_power     = cfg_q[7:0];
  assign lnk.cfg_reset     = cfg_q[15:8];
  assign lnk.cfg_tristate  = cfg_q[23:16];
  assign lnk.cfg_sync      = cfg_q[31:24];
  assign lnk.cfg_sof_delay = cfg_q[39:32];
  assign lnk.cfg_row_delay = cfg_q[47:40];
  assign lnk.cfg_lengths   = cfg_q[55:48];
  assign lnk.cfg_pix_delay = cfg_q[63:56];
  assign wr_done           = done_q;

  //////////////////////////////////////////////////////////////////////////////
  // Capture of pixel stream and timing edges, gated by enables
  logic row_q, adv_q, row_d, adv_d, ps_q, ps_d, fb_q, fb_d, rb_q, rb_d;
  sensor_ctl_pkg::pixel_t pv_q, pv_d;
  always_comb begin
    row_d = lnk.timing_oe & lnk.row_start_o;
    adv_d = lnk.timing_oe & lnk.row_advance_signal_o;
    ps_d  = lnk.pixel_oe & lnk.pixel_valid_o;
    pv_d  = ps_d ? lnk.pixel_data : pv_q;
    fb_d  = row_d & ~row_q;
    rb_d  = adv_d & ~adv_q;
    if (srst) begin
      row_d = 1'b0;
      adv_d = 1'b0;
      ps_d  = 1'b0;
      pv_d  = 10'h000;
      fb_d  = 1'b0;
      rb_d  = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    row_q <= row_d;
    adv_q <= adv_d;
    ps_q  <= ps_d;
    pv_q  <= pv_d;
    fb_q  <= fb_d;
    rb_q  <= rb_d;
  end
  assign pixel_strobe = ps_q;
  assign pixel_value  = pv_q;
  assign frame_begin  = fb_q;
  assign row_begin    = rb_q;
endmodule : sensor_ctl_host

// ### hdl/sensor_ctl_if.sv
// Link between the sensor control device and its controller
`timescale 1ns/1ps
interface sensor_ctl_if;
  logic                    init;
  logic                    sync_in;
  logic [7:0]              cfg_power;
  logic [7:0]              cfg_reset;
  logic [7:0]              cfg_tristate;
  logic [7:0]              cfg_sync;
  logic [7:0]              cfg_sof_delay;
  logic [7:0]              cfg_row_delay;
  logic [7:0]              cfg_lengths;
  logic [7:0]              cfg_pix_delay;
  logic                    cfg_we;
  logic                    capture_start_o;
  logic                    capture_start_oe;
  logic                    row_start_o;
  logic                    row_advance_signal_o;
  logic                    pixel_valid_o;
  logic                    flash_trigger_o;
  logic                    timing_oe;
  logic                    pixel_oe;
  sensor_ctl_pkg::pixel_t  pixel_data;
  logic                    analog_power_down;
  logic                    ext_bias_sel;
  logic                    cfg_accept;
  logic                    ready;
  modport device (input init, sync_in, cfg_power, cfg_reset, cfg_tristate, cfg_sync,
                  cfg_sof_delay, cfg_row_delay, cfg_lengths, cfg_pix_delay, cfg_we,
                  output capture_start_o, capture_start_oe, row_start_o,
                  row_advance_signal_o, pixel_valid_o, flash_trigger_o, timing_oe,
                  pixel_oe, pixel_data, analog_power_down, ext_bias_sel, cfg_accept,
                  ready);
  modport host (output init, sync_in, cfg_power, cfg_reset, cfg_tristate, cfg_sync,
                cfg_sof_delay, cfg_row_delay, cfg_lengths, cfg_pix_delay, cfg_we,
                input capture_start_o, capture_start_oe, row_start_o,
                row_advance_signal_o, pixel_valid_o, flash_trigger_o, timing_oe,
                pixel_oe, pixel_data, analog_power_down, ext_bias_sel, cfg_accept,
                ready);
endinterface : sensor_ctl_if

// ### hdl/sensor_ctl_pkg.sv
// Types shared by both ends of the sensor control link
package sensor_ctl_pkg;
  typedef enum logic [4:0] {
    ST_INIT    = 5'h01,
    ST_STARTUP = 5'h02,
    ST_FRAME   = 5'h04,
    ST_ROW     = 5'h08,
    ST_PIXELS  = 5'h10
  } seq_state_t;
  typedef logic [9:0] pixel_t;
endpackage : sensor_ctl_pkg

// ### verification/sensor_ctl_chk.sv
// Assertion checker watching the sensor control link signals
`timescale 1ns/1ps
module sensor_ctl_chk (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       init,
  input wire logic [7:0] cfg_power,
  input wire logic [7:0] cfg_reset,
  input wire logic [7:0] cfg_tristate,
  input wire logic       cfg_we,
  input wire logic       cfg_accept,
  input wire logic       ready,
  input wire logic       timing_oe,
  input wire logic       pixel_oe,
  input wire logic       analog_power_down,
  input wire logic       ext_bias_sel,
  input wire logic       row_start_o,
  input wire logic       pixel_valid_o
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // A configuration word taken by the device
  sequence cfg_take;
    cfg_we && cfg_accept;
  endsequence
  // Two edges of init let the registered state settle first
  sequence init_held;
    init ##1 init;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  init_float_a: assert property (init_held |-> !timing_oe && !pixel_oe && analog_power_down)
    else $error("outputs not floated during init");
  write_gate_a: assert property (init |-> !cfg_accept ##1 !cfg_accept)
    else $error("write accepted during or just after init");
  init_width_a: assert property ($rose(init) |-> init [*8])
    else $error("init pulse shorter than minimum");
  startup_run_a: assert property ($fell(init) |-> !ready [*4] ##[1:4] ready)
    else $error("startup length wrong");
  standby_on_a: assert property (cfg_take ##0 cfg_power[0] |=> analog_power_down)
    else $error("standby did not power down");
  standby_off_a: assert property (cfg_take ##0 !cfg_power[0] |=> !analog_power_down)
    else $error("standby not left");
  bias_select_a: assert property (cfg_take |=> ext_bias_sel == $past(cfg_power[1]))
    else $error("bias select mismatch");
  tri_float_a: assert property (cfg_take ##0 cfg_tristate[0] |=> !timing_oe && !pixel_oe)
    else $error("tristate not applied");
  state_quiet_a: assert property (cfg_take ##0 (cfg_reset[1] && !cfg_power[0])
    |=> !analog_power_down ##1 (!row_start_o && !pixel_valid_o))
    else $error("state reset not quiet");
endmodule : sensor_ctl_chk

// ### verification/sensor_ctl_test.sv
// Self-checking bench joining the controller and sensor ends
`timescale 1ns/1ps
`include "sensor_ctl_cfg.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module sensor_ctl_test;
  logic                   core_clk = 1'b0;
  logic                   srst = 1'b1;
  logic                   init_req = 1'b0;
  logic                   hold_low_power = 1'b0;
  logic                   wr_req = 1'b0;
  logic [63:0]            wr_cfg = 64'h0;
  logic                   ext_sync_level = 1'b0;
  logic                   init_busy;
  logic                   wr_done;
  logic                   pixel_strobe;
  sensor_ctl_pkg::pixel_t pixel_value;
  logic                   row_begin;
  logic                   frame_begin;
  int                     err_total = 0;
  int                     check_count = 0;
  int                     cyc = 0;
  int                     pv, ps, ra, cs, fr, fb, rb, pk, n;
  sensor_ctl_pkg::pixel_t last_pix;
  sensor_ctl_if lnk();
  sensor_ctl_device sensor_ctl_device_inst (.core_clk(core_clk), .srst(srst), .lnk(lnk));
  sensor_ctl_host sensor_ctl_host_inst (.core_clk(core_clk), .srst(srst), .init_req(init_req),
    .hold_low_power(hold_low_power), .wr_req(wr_req), .wr_cfg(wr_cfg),
    .ext_sync_level(ext_sync_level), .init_busy(init_busy), .wr_done(wr_done),
    .pixel_strobe(pixel_strobe), .pixel_value(pixel_value), .row_begin(row_begin),
    .frame_begin(frame_begin), .lnk(lnk));
  sensor_ctl_chk sensor_ctl_chk_inst (.core_clk(core_clk), .srst(srst), .init(lnk.init),
    .cfg_power(lnk.cfg_power), .cfg_reset(lnk.cfg_reset), .cfg_tristate(lnk.cfg_tristate),
    .cfg_we(lnk.cfg_we), .cfg_accept(lnk.cfg_accept), .ready(lnk.ready),
    .timing_oe(lnk.timing_oe), .pixel_oe(lnk.pixel_oe),
    .analog_power_down(lnk.analog_power_down), .ext_bias_sel(lnk.ext_bias_sel),
    .row_start_o(lnk.row_start_o), .pixel_valid_o(lnk.pixel_valid_o));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; a full run needs well under 5000 cycles
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  // Bounded wait for the startup sequence to finish
  task automatic wait_ready();
    // Look one step after each edge so registered outputs have settled
    for (n = 0; n < 60 && lnk.ready !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK(lnk.ready, 1'b1)
  endtask : wait_ready
  // Pulse init and look at the link while it is held
  task automatic start_init();
    init_req <= 1'b1;
    @(posedge core_clk);
    init_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK({init_busy, lnk.timing_oe, lnk.cfg_accept}, 3'b100)
    wait_ready();
  endtask : start_init
  // One configuration word; timing fields stay at their defaults
  task automatic write_cfg(input logic [7:0] pwr, rst, tri_s, sync);
    @(posedge core_clk);
    wr_cfg <= {`DEF_PIX_DELAY, `DEF_ROW_LEN, `DEF_SOF_LEN, `DEF_ROW_DELAY,
               `DEF_SOF_DELAY, sync, tri_s, rst, pwr};
    wr_req <= 1'b1;
    @(posedge core_clk);
    wr_req <= 1'b0;
    // The done pulse stands one cycle; look at it after the edge that raises it
    for (n = 0; n < 40 && wr_done !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK(wr_done, 1'b1)
    repeat (2) @(posedge core_clk);
    #1;
  endtask : write_cfg
  // Count pulses; watches of 300 or more count only between the first two row starts, shorter ones the whole window
  task automatic watch(input int lim);
    pv = 0;
    ps = 0;
    ra = 0;
    cs = 0;
    fr = 0;
    fb = 0;
    rb = 0;
    pk = 0;
    last_pix = pixel_value;
    for (n = 0; n < lim && fr < 2; n++) begin
      @(negedge core_clk);
      fr += (lnk.row_start_o === 1'b1);
      if (fr == 1 || lim < 300) begin
        pv += lnk.pixel_valid_o;
        ps += pixel_strobe;
        ra += lnk.row_advance_signal_o;
        cs += lnk.capture_start_o;
        fb += frame_begin;
        rb += row_begin;
        // Each captured pixel after the first in the window must be one above the last
        if (pixel_strobe === 1'b1 && ps > 1) pk += (pixel_value == last_pix + 10'h001);
      end
      if (pixel_strobe === 1'b1) last_pix = pixel_value;
    end
  endtask : watch
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    start_init();
    `CHK({lnk.analog_power_down, lnk.ext_bias_sel}, 2'b00)
    write_cfg(8'h00, 8'h00, 8'h00, 8'h02);
    `CHK(lnk.capture_start_oe, 1'b1)
    watch(1000);
    `CHK(pv, 32'h00000080)
    `CHK(ps, 32'h00000080)
    `CHK(pk, 32'h0000007F)
    `CHK(ra, 32'h00000008)
    `CHK(rb, 32'h00000008)
    `CHK(cs, 32'h00000001)
    `CHK(fr, 32'h00000002)
    `CHK(fb, 32'h00000001)
    write_cfg(8'h02, 8'h00, 8'h01, 8'h01);
    @(posedge core_clk);
    ext_sync_level <= 1'b1;
    #1;
    `CHK(lnk.capture_start_o, 1'b1)
    `CHK(lnk.ext_bias_sel, 1'b1)
    `CHK({lnk.timing_oe, lnk.pixel_oe, lnk.capture_start_oe}, 3'b000)
    write_cfg(8'h01, 8'h00, 8'h00, 8'h02);
    `CHK(lnk.analog_power_down, 1'b1)
    watch(100);
    `CHK({fr, pv}, 64'h0)
    write_cfg(8'h00, 8'h02, 8'h00, 8'h02);
    watch(100);
    `CHK({fr, pv, 31'h0, lnk.analog_power_down}, 96'h0)
    write_cfg(8'h02, 8'h00, 8'h00, 8'h02);
    watch(1000);
    `CHK({fr, pv}, {32'h00000002, 32'h00000080})
    @(posedge core_clk);
    hold_low_power <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    `CHK({init_busy, lnk.analog_power_down, lnk.ready}, 3'b110)
    @(posedge core_clk);
    hold_low_power <= 1'b0;
    wait_ready();
    `CHK(lnk.ext_bias_sel, 1'b0)
    watch(1000);
    `CHK({fr, pv}, {32'h00000002, 32'h00000080})
    `CHK(pk, 32'h0000007F)
    close_out();
  end
endmodule : sensor_ctl_test
